// ===== clk_source_model.sv
// Far-side model: clock/SYSREF source and supply monitor feeding the block's pins.
// Assumes the testbench calls its tasks; pins change just after a rising ref_clk edge.
`timescale 1ns/1ns
module clk_source_model (
  input wire logic ref_clk,
  output logic sysref_in,
  output logic supplies_valid_in
);
  // SYSREF idles low between events for best spurious behaviour
  initial begin
    sysref_in = 1'b0;
    supplies_valid_in = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One SYSREF event, held long enough to pass the pin synchroniser
  task automatic sysref_pulse();
    @(posedge ref_clk);
    sysref_in <= 1'b1;
    repeat (6) @(posedge ref_clk);
    sysref_in <= 1'b0;
  endtask

  // Supplies and clock become valid and stay so
  task automatic power_good();
    @(posedge ref_clk);
    supplies_valid_in <= 1'b1;
  endtask
endmodule

// ===== clkcal_pkg.sv
// Shared constants and types for the sampling clock, alignment gate and calibration control.
// Assumes a 32-bit APB register bus and a single clock that is the device clock itself.
package clkcal_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DRIVER = 8'h04;
  localparam logic [7:0] OFF_LINK_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Field layouts
  // Control word: phase [8:5], power down [4], offset enable [3], gate enable [2], divide select [1:0]
  typedef struct packed {
    logic [3:0] phase;
    logic power_down;
    logic sysref_offset_en;
    logic sysref_gate_en;
    logic [1:0] clock_divide_factor;
  } ctrl_type;
  localparam int CTRL_W = 9;

  // Driver word: de-emphasis [5:3], swing [2:0]
  typedef struct packed {
    logic [2:0] deemphasis_setting;
    logic [2:0] driver_swing_setting;
  } driver_type;
  localparam int DRIVER_W = 6;

  localparam ctrl_type CTRL_RESET = 9'h000;
  localparam driver_type DRIVER_RESET = 6'h00;

  // Link status word bits
  localparam int STS_CAL_DONE = 0;
  localparam int STS_CAL_BUSY = 1;
  localparam int STS_PWRUP_WAIT = 2;
  localparam int STS_W = 3;

  // Interrupt bits, same layout in status, clear and enable
  localparam int IRQ_CAL_DONE = 0;
  localparam int IRQ_SYSREF = 1;
  localparam int IRQ_REINIT = 2;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing, in sampling clock cycles
  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] POWERUP_CYCLES_DEF = 24'h802c80; // 8.4e6
  localparam logic [CNT_W-1:0] CAL_CYCLES_DEF = 24'h1e8480; // 2.0e6
  localparam int DIV_CNT_W = 3;

  typedef enum logic [3:0] {
    ST_WAIT_SUPPLY,
    ST_POWERUP,
    ST_CAL,
    ST_DONE,
    ST_PWRDN
  } cal_state_type;

  // Divide select 0..3 gives factor 1, 2, 4, 8
  function automatic logic [3:0] factor_of(input logic [1:0] sel);
    factor_of = 4'h1 << sel;
  endfunction

endpackage

// ===== clock_sysref_cal_ctrl.sv
// Clock divider control, gated SYSREF alignment and core calibration sequencing behind APB.
// Assumes ref_clk is the device clock; sysref_in and supplies_valid_in are asynchronous pins.
//
// Overview of operation
// - Sampling clock is the device clock divided by 1, 2, 4 or 8.
// - Any change of divide factor starts a full serial link re-initialisation.
// - SYSREF reaches internal logic only through the gate; closed gate changes nothing.
// - Gate is closed after reset until the host opens it.
// - SYSREF offset and gate enable are host-written configuration bits.
// - Coarse phase moves in half device clock steps, twice the factor steps total.
// - One coarse phase setting serves both channels.
// - Phase changes leave frame clocks, link status and output data undisturbed.
// - Phase change shifts sample-to-frame latency by exactly that change.
// - Each accepted SYSREF event realigns the sampling clock phase.
// - Eight swing and eight de-emphasis levels, each in its own field.
// - After supplies and clock are valid, wait fixed sampling cycles, then self-calibrate.
// - A calibration run lasts about two million sampling cycles.
`timescale 1ns/1ns
module clock_sysref_cal_ctrl
  import clkcal_pkg::*;
#(
  parameter logic [CNT_W-1:0] POWERUP_CYCLES = POWERUP_CYCLES_DEF,
  parameter logic [CNT_W-1:0] CAL_CYCLES = CAL_CYCLES_DEF
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sysref_in,
  input wire logic supplies_valid_in,
  output logic sysref_offset_en,
  output logic [2:0] driver_swing_setting,
  output logic [2:0] deemphasis_setting,
  output logic link_reinit,
  output logic sample_tick,
  output logic sample_half,
  output logic frame_tick,
  output logic sysref_aligned,
  output logic cal_done,
  output logic irq
);

  localparam int NPIN = 2;
  localparam int PIN_SYSREF = 0;
  localparam int PIN_SUPPLY = 1;

  logic [NPIN-1:0] pin_in;
  logic [NPIN-1:0] s1_r, s2_r, s3_r, lvl_r;
  logic sysref_prev_r;
  logic sysref_edge;
  logic accepted;

  ctrl_type ctrl_r, ctrl_nxt;
  driver_type drv_r, drv_nxt;
  logic [IRQ_W-1:0] ists_r, ists_nxt;
  logic [IRQ_W-1:0] ien_r, ien_nxt;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] clr_mask;
  logic [31:0] prdata_r, prdata_nxt;
  logic reinit_r, reinit_nxt;
  logic aligned_r;
  logic wr_access;
  logic rd_setup;

  cal_state_type state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic cal_done_r, cal_done_nxt;
  logic cal_finish;
  logic [STS_W-1:0] link_status_word;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Offsets that answer; everything else is an error
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == OFF_CTRL) || (a == OFF_DRIVER) || (a == OFF_LINK_STATUS) ||
              (a == OFF_IRQ_STATUS) || (a == OFF_IRQ_CLEAR) || (a == OFF_IRQ_ENABLE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; a level counts once the second and third stages agree
  assign pin_in = {supplies_valid_in, sysref_in};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          s3_r[gi] <= 1'b0;
          lvl_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= pin_in[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            lvl_r[gi] <= s3_r[gi];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Detection gate: an AND in front of the alignment logic
  assign sysref_edge = lvl_r[PIN_SYSREF] & ~sysref_prev_r;
  assign accepted = sysref_edge & ctrl_r.sysref_gate_en;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sysref_prev_r <= 1'b0;
      aligned_r <= 1'b0;
    end else begin
      sysref_prev_r <= lvl_r[PIN_SYSREF];
      aligned_r <= accepted;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider and phase placement
  sample_clock_divider u_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .div_sel(ctrl_r.clock_divide_factor),
    .phase(ctrl_r.phase),
    .realign(accepted),
    .sample_tick(sample_tick),
    .sample_half(sample_half),
    .frame_tick(frame_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB register file; writes land in the access phase, read data is caught in setup
  assign wr_access = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign events = {reinit_r, accepted, cal_finish};
  assign link_status_word = {state_r == ST_POWERUP, state_r == ST_CAL, cal_done_r};

  always_comb begin
    ctrl_nxt = ctrl_r;
    drv_nxt = drv_r;
    ien_nxt = ien_r;
    clr_mask = '0;
    reinit_nxt = 1'b0;
    prdata_nxt = prdata_r;
    if (wr_access) begin
      case (paddr)
        OFF_CTRL: begin
          ctrl_nxt = ctrl_type'(pwdata[CTRL_W-1:0]);
          // Only a real change of factor restarts the link
          reinit_nxt = (ctrl_nxt.clock_divide_factor != ctrl_r.clock_divide_factor);
        end
        OFF_DRIVER: begin
          drv_nxt = driver_type'(pwdata[DRIVER_W-1:0]);
        end
        OFF_IRQ_CLEAR: begin
          clr_mask = pwdata[IRQ_W-1:0];
        end
        OFF_IRQ_ENABLE: begin
          ien_nxt = pwdata[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // Set wins over clear so no event is lost
    ists_nxt = (ists_r & ~clr_mask) | events;
    if (rd_setup) begin
      case (paddr)
        OFF_CTRL: prdata_nxt = {{(32-CTRL_W){1'b0}}, ctrl_r};
        OFF_DRIVER: prdata_nxt = {{(32-DRIVER_W){1'b0}}, drv_r};
        OFF_LINK_STATUS: prdata_nxt = {{(32-STS_W){1'b0}}, link_status_word};
        OFF_IRQ_STATUS: prdata_nxt = {{(32-IRQ_W){1'b0}}, ists_r};
        OFF_IRQ_ENABLE: prdata_nxt = {{(32-IRQ_W){1'b0}}, ien_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= CTRL_RESET;
      drv_r <= DRIVER_RESET;
      ists_r <= IRQ_RESET;
      ien_r <= IRQ_RESET;
      reinit_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      drv_r <= drv_nxt;
      ists_r <= ists_nxt;
      ien_r <= ien_nxt;
      reinit_r <= reinit_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Zero wait states; unmapped offsets answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok(paddr);
  assign prdata = prdata_r;
  assign sysref_offset_en = ctrl_r.sysref_offset_en;
  assign driver_swing_setting = drv_r.driver_swing_setting;
  assign deemphasis_setting = drv_r.deemphasis_setting;
  assign link_reinit = reinit_r;
  assign sysref_aligned = aligned_r;
  assign irq = |(ists_r & ien_r);

  ////////////////////////////////////////////////////////////////////////////
  // Calibration sequencer, counting sampling cycles
  assign cal_finish = (state_r == ST_CAL) && sample_tick && (cnt_r == CAL_CYCLES - 24'h1);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_WAIT_SUPPLY: begin
        if (lvl_r[PIN_SUPPLY]) begin
          state_nxt = ST_POWERUP;
          cnt_nxt = '0;
        end
      end
      ST_POWERUP: begin
        if (sample_tick) begin
          if (cnt_r == POWERUP_CYCLES - 24'h1) begin
            state_nxt = ST_CAL;
            cnt_nxt = '0;
          end else begin
            cnt_nxt = cnt_r + 24'h1;
          end
        end
      end
      ST_CAL: begin
        if (sample_tick) begin
          if (cal_finish) begin
            state_nxt = ST_DONE;
          end else begin
            cnt_nxt = cnt_r + 24'h1;
          end
        end
      end
      ST_DONE: begin
      end
      ST_PWRDN: begin
        // Leaving power down starts a manual calibration
        if (!ctrl_r.power_down) begin
          state_nxt = ST_CAL;
          cnt_nxt = '0;
        end
      end
      default: begin
        state_nxt = ST_WAIT_SUPPLY;
      end
    endcase
    // Power down overrides any run; a partial calibration is abandoned
    if (ctrl_r.power_down) begin
      state_nxt = ST_PWRDN;
    end
    cal_done_nxt = (state_nxt == ST_DONE);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_WAIT_SUPPLY;
      cnt_r <= '0;
      cal_done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cal_done_r <= cal_done_nxt;
    end
  end

  assign cal_done = cal_done_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_gate_blocks_sysref: assert property (sysref_edge && !ctrl_r.sysref_gate_en |=> !sysref_aligned)
    else $error("sysref passed a closed gate");
  a_gate_opened_write: assert property ($rose(ctrl_r.sysref_gate_en) |->
    $past(wr_access) && $past(paddr) == OFF_CTRL)
    else $error("gate opened without a host write");
  a_reinit_on_divide: assert property ($changed(ctrl_r.clock_divide_factor) |-> link_reinit ##1 !link_reinit)
    else $error("divide change without one reinit pulse");
  a_phase_no_reinit: assert property ($changed(ctrl_r.phase) && $stable(ctrl_r.clock_divide_factor) |->
    !link_reinit)
    else $error("phase change disturbed the link");
  a_done_low_running: assert property (state_r == ST_CAL |-> !cal_done && link_status_word[STS_CAL_BUSY])
    else $error("done flag high during calibration");
  a_done_after_run: assert property (cal_finish && !ctrl_r.power_down |=> cal_done)
    else $error("done flag missing after calibration");
  a_powerup_then_cal: assert property (state_r == ST_POWERUP && sample_tick &&
    cnt_r == POWERUP_CYCLES - 24'h1 && !ctrl_r.power_down |=> state_r == ST_CAL && cnt_r == '0)
    else $error("no calibration after power-up delay");
  a_cal_count_bound: assert property (state_r == ST_CAL |-> cnt_r < CAL_CYCLES)
    else $error("calibration ran past its length");
  a_driver_fields: assert property (wr_access && paddr == OFF_DRIVER |=>
    driver_swing_setting == $past(pwdata[2:0]) && deemphasis_setting == $past(pwdata[5:3]))
    else $error("driver fields not taken from write");
  a_realign_pulse: assert property (accepted |=> sysref_aligned ##1 !sysref_aligned || accepted)
    else $error("accepted sysref not flagged");
  a_irq_level: assert property (ists_r[IRQ_SYSREF] && ien_r[IRQ_SYSREF] |-> irq)
    else $error("interrupt level wrong");
  a_irq_sticky: assert property (events[IRQ_CAL_DONE] |=> ists_r[IRQ_CAL_DONE])
    else $error("calibration event not latched");

  c_cal_complete: cover property (cal_finish);
  c_sysref_taken: cover property (accepted);
  c_divide_change: cover property (link_reinit);
  c_manual_cal: cover property (state_r == ST_PWRDN ##1 state_r == ST_CAL);

endmodule

// ===== sample_clock_divider.sv
// Divides the device clock to the sampling rate and places the sampling strobe by the coarse phase.
// Assumes ref_clk is the device clock and realign is a one-cycle pulse from the same domain.
`timescale 1ns/1ns
module sample_clock_divider
  import clkcal_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] div_sel,
  input wire logic [3:0] phase,
  input wire logic realign,
  output logic sample_tick,
  output logic sample_half,
  output logic frame_tick
);

  logic [DIV_CNT_W-1:0] cnt_r, cnt_nxt;
  logic tick_r, tick_nxt;
  logic half_r, half_nxt;
  logic frame_r, frame_nxt;
  logic [3:0] factor;
  logic [3:0] mask;
  logic [3:0] eff_phase;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Next values of the divider and its strobes
  always_comb begin
    factor = factor_of(div_sel);
    mask = 4'((factor << 1) - 4'h1); // Wraps to all ones for factor 8
    eff_phase = phase & mask;
    if (realign) begin
      cnt_nxt = '0;
    end else if ({1'b0, cnt_r} >= factor - 4'h1) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + 3'h1;
    end
    // One strobe feeds both channels
    tick_nxt = (cnt_r == eff_phase[3:1]);
    half_nxt = eff_phase[0];
    // Frame timing ignores phase; samples are retimed onto it
    frame_nxt = (cnt_r == '0);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
      half_r <= 1'b0;
      frame_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
      half_r <= half_nxt;
      frame_r <= frame_nxt;
    end
  end

  assign sample_tick = tick_r;
  assign sample_half = half_r;
  assign frame_tick = frame_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_count_range: assert property ($stable(div_sel) |-> {1'b0, cnt_r} < factor)
    else $error("divider count beyond factor");
  a_phase_steps: assert property (eff_phase < (5'(factor) << 1))
    else $error("phase step outside one sampling period");
  a_realign_zero: assert property (realign |=> cnt_r == '0 ##1 frame_tick)
    else $error("divider not realigned on sysref");
  a_frame_fixed: assert property ($changed(phase) && $stable(div_sel) && !realign |=>
    $past(cnt_r) != cnt_r || factor == 4'h1)
    else $error("phase change disturbed frame timing");

endmodule

// ===== test_clock_sysref_cal_ctrl.sv
// Self-checking bench for the clock, SYSREF gate and calibration control block.
// Assumes zero-wait APB slave and shortened power-up and calibration counts.
`timescale 1ns/1ns
`define chk(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module test_clock_sysref_cal_ctrl;
  import clkcal_pkg::*;
  localparam logic [CNT_W-1:0] PU = 24'h000014;
  localparam logic [CNT_W-1:0] CAL = 24'h00000a;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e;
  logic sysref_in, supplies_valid_in, sysref_offset_en, link_reinit;
  logic [2:0] driver_swing_setting, deemphasis_setting;
  logic sample_tick, sample_half, frame_tick, sysref_aligned, cal_done, irq;
  int n_mismatch = 0, checks_done = 0, cyc = 0, reinit_cnt = 0, n;
  bit seen;

  always #10 ref_clk = ~ref_clk;

  clk_source_model i_clk_source_model (.ref_clk(ref_clk), .sysref_in(sysref_in),
    .supplies_valid_in(supplies_valid_in));

  clock_sysref_cal_ctrl #(.POWERUP_CYCLES(PU), .CAL_CYCLES(CAL)) i_clock_sysref_cal_ctrl (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sysref_in(sysref_in), .supplies_valid_in(supplies_valid_in),
    .sysref_offset_en(sysref_offset_en), .driver_swing_setting(driver_swing_setting),
    .deemphasis_setting(deemphasis_setting), .link_reinit(link_reinit),
    .sample_tick(sample_tick), .sample_half(sample_half), .frame_tick(frame_tick),
    .sysref_aligned(sysref_aligned), .cal_done(cal_done), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard and link re-init pulse counter
  always @(posedge ref_clk) begin
    cyc++;
    if (link_reinit === 1'b1) reinit_cnt++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Control word from phase, power down and divide; offset and gate enable always set
  function automatic logic [31:0] ctrl(input logic [3:0] ph, input logic pd, input logic [1:0] dv);
    ctrl = {23'h0, ph, pd, 2'b11, dv};
  endfunction

  // Watch sysref_aligned for a bounded window
  task automatic watch_aligned(output bit s);
    s = 0;
    repeat (20) begin
      @(negedge ref_clk);
      if (sysref_aligned === 1'b1) s = 1;
    end
  endtask

  // Cycles from one strobe to the next (which: 0 sample, 1 frame)
  task automatic period(input bit which, output int p);
    p = 0;
    // Let the divider settle after a setting change
    repeat (8) @(negedge ref_clk);
    do @(negedge ref_clk); while ((which ? frame_tick : sample_tick) !== 1'b1 && ++p < 40);
    p = 0;
    do begin @(negedge ref_clk); p++; end while ((which ? frame_tick : sample_tick) !== 1'b1 && p < 40);
  endtask

  // Cycles from a frame strobe to the following sample strobe
  task automatic offset(output int p);
    p = 0;
    // Old phase strobes may linger for a few cycles
    repeat (8) @(negedge ref_clk);
    do @(negedge ref_clk); while (frame_tick !== 1'b1 && ++p < 40);
    p = 0;
    while (sample_tick !== 1'b1 && p < 40) begin @(negedge ref_clk); p++; end
  endtask

  task automatic wait_cal(output int p);
    p = 0;
    while (cal_done !== 1'b1 && p < 400) begin @(negedge ref_clk); p++; end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    apb(0, OFF_CTRL, 0, q, e);
    `chk(q, 32'h0)
    apb(0, OFF_DRIVER, 0, q, e);
    `chk(q, 32'h0)
    apb(0, 8'h40, 0, q, e);
    `chk(e, 1'b1)
    // Closed gate: a SYSREF edge must go unseen
    fork
      i_clk_source_model.sysref_pulse();
      watch_aligned(seen);
    join
    `chk(seen, 1'b0)
    i_clk_source_model.power_good();
    repeat (8) @(posedge ref_clk);
    apb(0, OFF_LINK_STATUS, 0, q, e);
    `chk(q, 32'h4)
    wait_cal(n);
    `chk(cal_done, 1'b1)
    apb(0, OFF_IRQ_STATUS, 0, q, e);
    `chk(q, 32'h1)
    apb(1, OFF_IRQ_CLEAR, 32'h1, q, e);
    apb(1, OFF_CTRL, ctrl(0, 0, 0), q, e);
    @(negedge ref_clk);
    `chk(sysref_offset_en, 1'b1)
    apb(1, OFF_IRQ_ENABLE, 32'h2, q, e);
    // The aligned pulse comes while the pin is still high
    fork
      i_clk_source_model.sysref_pulse();
      watch_aligned(seen);
    join
    `chk(seen, 1'b1)
    `chk(irq, 1'b1)
    apb(0, OFF_IRQ_STATUS, 0, q, e);
    `chk(q, 32'h2)
    apb(1, OFF_IRQ_CLEAR, 32'h2, q, e);
    @(negedge ref_clk);
    `chk(irq, 1'b0)
    // Every divide factor, each change re-initialising the link
    for (int s = 0; s < 4; s++) begin
      apb(1, OFF_CTRL, ctrl(0, 0, s[1:0]), q, e);
      period(0, n);
      `chk(n, 1 << s)
    end
    `chk(reinit_cnt, 3)
    apb(0, OFF_IRQ_STATUS, 0, q, e);
    `chk(q[IRQ_REINIT], 1'b1)
    // Manual recalibration at factor 8
    apb(1, OFF_CTRL, ctrl(0, 1, 3), q, e);
    // Done falls one edge after the power-down bit lands
    repeat (2) @(negedge ref_clk);
    `chk(cal_done, 1'b0)
    apb(1, OFF_CTRL, ctrl(0, 0, 3), q, e);
    apb(0, OFF_LINK_STATUS, 0, q, e);
    `chk(q, 32'h2)
    wait_cal(n);
    `chk(n > 60 && n < 90, 1'b1)
    apb(0, OFF_LINK_STATUS, 0, q, e);
    `chk(q, 32'h1)
    // Coarse phase at factor 4, masked to eight steps
    apb(1, OFF_CTRL, ctrl(4'h1, 0, 2), q, e);
    offset(n);
    `chk(n, 0)
    `chk(sample_half, 1'b1)
    apb(1, OFF_CTRL, ctrl(4'h5, 0, 2), q, e);
    offset(n);
    `chk(n, 2)
    `chk(sample_half, 1'b1)
    apb(1, OFF_CTRL, ctrl(4'hc, 0, 2), q, e);
    offset(n);
    `chk(n, 2)
    `chk(sample_half, 1'b0)
    period(1, n);
    `chk(n, 4)
    // Only the move from factor 8 to 4 re-initialised; phase writes did not
    `chk(reinit_cnt, 4)
    // Driver fields and an ignored unmapped write
    apb(1, OFF_DRIVER, 32'h2f, q, e);
    @(negedge ref_clk);
    `chk(driver_swing_setting, 3'h7)
    `chk(deemphasis_setting, 3'h5)
    apb(1, 8'h40, 32'hffffffff, q, e);
    `chk(e, 1'b1)
    apb(0, OFF_DRIVER, 0, q, e);
    `chk(q, 32'h2f)
    test_done();
  end
endmodule
